// ==== design/epc_ctrl.sv ====
// Purpose: drives an erasable parallel memory through its pins: read, id, program, erase
// Assumes: level shifters turn vpp_sel and id_erase_address_pin_hv into real voltages
// Notes: one command at a time; cmd_ready high while idle
`timescale 1ns/10ps
module epc_ctrl #(
    parameter int unsigned erase_budget_cyc = epc_pkg::epc_erase_budget_cyc
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire epc_pkg::epc_cmd_t cmd_op,
    input wire logic [16:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata,
    output logic rsp_error,
    output logic [16:0] address_lines,
    output logic id_erase_address_pin_hv,
    output logic [7:0] data_lines_o,
    output logic data_lines_oe,
    input wire logic [7:0] data_lines_i,
    output logic chip_select_n,
    output logic output_gate_n,
    output logic write_pulse_n,
    output epc_pkg::epc_vpp_t vpp_sel
);
    // ****************************************
    // state and timer
    // ****************************************
    typedef enum {
        st_idle, st_setup, st_pulse, st_hold, st_vsetup, st_verify, st_next, st_done
    } epc_state_t;

    epc_state_t state_q;
    epc_pkg::epc_cmd_t op_q;
    logic [16:0] addr_q;
    logic [7:0] wdata_q;
    logic [7:0] tries_q;
    logic [21:0] budget_q;
    logic wait_q;
    logic fail_q;
    epc_timer_if tif ();

    epc_timer u_timer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .tif(tif)
    );

    logic go;
    logic is_write;
    logic verify_ok;
    assign go = cmd_valid && cmd_ready;
    assign cmd_ready = (state_q == st_idle);
    assign is_write = (op_q == epc_pkg::epc_cmd_program) || (op_q == epc_pkg::epc_cmd_erase);
    // erase verify checks FF, program verify checks the written byte
    assign verify_ok = (op_q == epc_pkg::epc_cmd_erase) ?
        (data_lines_i == epc_pkg::epc_erased_byte) : (data_lines_i == wdata_q);

    // ****************************************
    // sequencer
    // ****************************************
    // st_setup to st_verify each advance when the timer reports done; st_next and st_done advance at once
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= st_idle;
            op_q <= epc_pkg::epc_cmd_read;
            addr_q <= 17'h0;
            wdata_q <= 8'h0;
            tries_q <= 8'h0;
            wait_q <= 1'b0;
            fail_q <= 1'b0;
        end
        else
        begin
            wait_q <= 1'b0;
            unique case (state_q)
                st_idle:
                    if (go)
                    begin
                        op_q <= cmd_op;
                        // erase starts at address 0, address lines low
                        addr_q <= (cmd_op == epc_pkg::epc_cmd_erase) ? 17'h0 : cmd_addr;
                        wdata_q <= cmd_wdata;
                        tries_q <= 8'h0;
                        fail_q <= 1'b0;
                        wait_q <= 1'b1;
                        state_q <= (cmd_op == epc_pkg::epc_cmd_program ||
                            cmd_op == epc_pkg::epc_cmd_erase) ? st_setup : st_verify;
                    end
                st_setup:
                    if (tif.done)
                    begin
                        wait_q <= 1'b1;
                        tries_q <= tries_q + 8'h1;
                        state_q <= st_pulse;
                    end
                st_pulse:
                    if (tif.done)
                    begin
                        wait_q <= 1'b1;
                        state_q <= st_hold; // pins unchanged until pulse ends
                    end
                st_hold:
                    if (tif.done)
                    begin
                        wait_q <= 1'b1;
                        state_q <= st_vsetup;
                    end
                st_vsetup:
                    if (tif.done)
                    begin
                        wait_q <= 1'b1;
                        state_q <= st_verify;
                    end
                st_verify:
                    if (tif.done)
                    begin
                        if (!is_write)
                            state_q <= st_done;
                        else if (op_q == epc_pkg::epc_cmd_erase && budget_q == 22'h0)
                        begin
                            // a slow erase is a failed erase, even in mid-walk
                            fail_q <= 1'b1;
                            state_q <= st_done;
                        end
                        else if (verify_ok && op_q == epc_pkg::epc_cmd_erase
                            && addr_q != epc_pkg::epc_last_addr)
                            state_q <= st_next; // walk every byte
                        else if (verify_ok)
                            state_q <= st_done;
                        else if (tries_q >= 8'(epc_pkg::epc_max_tries) || budget_q == 22'h0)
                        begin
                            fail_q <= 1'b1;
                            state_q <= st_done;
                        end
                        else
                        begin
                            // retry: another pulse, erase resumes at the failing byte
                            wait_q <= 1'b1;
                            state_q <= st_setup;
                        end
                    end
                st_next:
                begin
                    addr_q <= addr_q + 17'h1;
                    wait_q <= 1'b1;
                    state_q <= st_verify;
                end
                st_done:
                    state_q <= st_idle;
            endcase
        end
    end

    // wait length per state
    always_comb
    begin
        tif.start = wait_q;
        case (state_q)
            st_pulse: tif.cycles = 22'(epc_pkg::epc_pulse_cyc);
            st_verify: tif.cycles = 22'(epc_pkg::epc_read_cyc);
            default: tif.cycles = 22'(epc_pkg::epc_setup_cyc);
        endcase
    end

    // ****************************************
    // erase budget
    // ****************************************
    // counts down while erasing; a fail is reported once spent
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            budget_q <= 22'h0;
        else if (go)
            budget_q <= 22'(erase_budget_cyc);
        else if (budget_q != 22'h0 && op_q == epc_pkg::epc_cmd_erase)
            budget_q <= budget_q - 22'h1;
    end

    // ****************************************
    // pin drive
    // ****************************************
    // pins are registered so they change only on state edges
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chip_select_n <= 1'b1;
            output_gate_n <= 1'b1;
            write_pulse_n <= 1'b1;
            data_lines_oe <= 1'b0;
            data_lines_o <= 8'h0;
            address_lines <= 17'h0;
            id_erase_address_pin_hv <= 1'b0;
            vpp_sel <= epc_pkg::epc_vpp_normal;
        end
        else
        begin
            // idle leaves the part in standby
            chip_select_n <= (state_q == st_idle || state_q == st_done);
            // gate low only for reads and verifies
            output_gate_n <= !(state_q == st_verify || state_q == st_next);
            write_pulse_n <= !(state_q == st_pulse);
            // data driven only with the gate high
            data_lines_oe <= is_write && (state_q == st_setup || state_q == st_pulse ||
                state_q == st_hold);
            data_lines_o <= (op_q == epc_pkg::epc_cmd_erase) ? epc_pkg::epc_erased_byte
                : wdata_q;
            if (op_q == epc_pkg::epc_cmd_erase && state_q != st_verify && state_q != st_next)
                address_lines <= epc_pkg::epc_erase_addr;
            else if (op_q == epc_pkg::epc_cmd_id_maker)
                address_lines <= epc_pkg::epc_erase_addr;
            else if (op_q == epc_pkg::epc_cmd_id_part)
                address_lines <= epc_pkg::epc_erase_addr | 17'h00001;
            else
                address_lines <= addr_q;
            id_erase_address_pin_hv <= (state_q != st_idle) && (op_q == epc_pkg::epc_cmd_id_maker
                || op_q == epc_pkg::epc_cmd_id_part || (op_q == epc_pkg::epc_cmd_erase &&
                (state_q == st_setup || state_q == st_pulse || state_q == st_hold)));
            if (state_q == st_idle)
                vpp_sel <= epc_pkg::epc_vpp_normal;
            else if (op_q == epc_pkg::epc_cmd_erase)
                vpp_sel <= epc_pkg::epc_vpp_erase;
            else if (op_q == epc_pkg::epc_cmd_program)
                vpp_sel <= epc_pkg::epc_vpp_program;
            else
                vpp_sel <= epc_pkg::epc_vpp_normal;
        end
    end

    // ****************************************
    // response
    // ****************************************
    // read data captured at the end of each verify window
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rsp_valid <= 1'b0;
            rsp_rdata <= 8'h0;
            rsp_error <= 1'b0;
        end
        else
        begin
            rsp_valid <= (state_q == st_done);
            if (state_q == st_verify && tif.done)
                rsp_rdata <= data_lines_i;
            if (state_q == st_done)
                rsp_error <= fail_q;
        end
    end
endmodule

// ==== design/epc_pkg.sv ====
// Purpose: constants and types for the nonvolatile memory programmer controller
// Assumes: 20 MHz ref_clk, memory pins driven directly by the controller
// Notes:
// What this block does
// - erase setup: high voltages, address low, data high
// - low write pulse starts chip erase
// - erase verify: every byte must read FF
// - program setup then low write pulse
// - verify each byte right after programming
// - select high ignores program and erase
// - full erase expected within about 100 ms
// - program pulse low 95 to 105 us
// - erase pulse low 95 to 105 us
package epc_pkg;
    localparam int unsigned epc_addr_w = 17;
    localparam int unsigned epc_data_w = 8;
    localparam logic [16:0] epc_last_addr = 17'h1ffff;
    localparam logic [16:0] epc_erase_addr = 17'h00200; // only the id/erase line set
    localparam logic [7:0] epc_erased_byte = 8'hff;
    localparam int unsigned epc_clk_khz = 20000;
    // pulse width, nominal figure in us
    localparam int unsigned epc_pulse_us = 100;
    localparam int unsigned epc_pulse_cyc = epc_pulse_us * epc_clk_khz / 1000;
    // setup and hold around pulses, 2 us least
    localparam int unsigned epc_setup_us = 2;
    localparam int unsigned epc_setup_cyc = (epc_setup_us * epc_clk_khz + 999) / 1000;
    // read settle time, 150 ns least
    localparam int unsigned epc_read_ns = 150;
    localparam int unsigned epc_read_cyc = (epc_read_ns * epc_clk_khz / 1000 + 999) / 1000;
    // erase budget, 100 ms
    localparam int unsigned epc_erase_budget_ms = 100;
    localparam int unsigned epc_erase_budget_cyc = epc_erase_budget_ms * epc_clk_khz;
    localparam int unsigned epc_max_tries = 25;
    localparam int unsigned epc_cnt_w = 22;
    typedef enum logic [2:0] {
        epc_cmd_read,
        epc_cmd_program,
        epc_cmd_erase,
        epc_cmd_id_maker,
        epc_cmd_id_part
    } epc_cmd_t;
    typedef enum logic [1:0] {
        epc_vpp_normal,
        epc_vpp_program,
        epc_vpp_erase
    } epc_vpp_t;
endpackage

// ==== design/epc_timer.sv ====
// Purpose: counts a requested number of ref_clk cycles
// Assumes: cycles at least 1
// Notes: a new start restarts the count
`timescale 1ns/10ps
module epc_timer (
    input wire logic ref_clk,
    input wire logic rst_n,
    epc_timer_if.timer tif
);
    logic [21:0] cnt_q;
    logic busy_q;
    logic done_q;

    // down counter, done pulses one cycle after the count runs out
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= 22'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            if (tif.start)
            begin
                cnt_q <= tif.cycles - 22'h1;
                busy_q <= 1'b1;
            end
            else if (busy_q)
            begin
                if (cnt_q == 22'h0)
                begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
                else
                begin
                    cnt_q <= cnt_q - 22'h1;
                end
            end
        end
    end

    assign tif.done = done_q;
endmodule

// ==== design/epc_timer_if.sv ====
// Purpose: carries a delay request and its completion between controller and timer
// Assumes: single ref_clk domain
// Notes: start is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/10ps
interface epc_timer_if;
    logic start;
    logic [21:0] cycles;
    logic done;
    modport ctrl (output start, output cycles, input done);
    modport timer (input start, input cycles, output done);
endinterface

// ==== test/epc_ctrl_asserts.sv ====
// Purpose: pin-level checks on the memory programmer controller
// Assumes: single ref_clk domain, rst_n active low
// Notes: pulse width counted in helper logic, 1900..2100 cycles at 20 MHz
`timescale 1ns/10ps
module epc_ctrl_asserts #(
    parameter int unsigned erase_budget_cyc = 20000
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic [16:0] address_lines,
    input wire logic id_erase_address_pin_hv,
    input wire logic [7:0] data_lines_o,
    input wire logic data_lines_oe,
    input wire logic chip_select_n,
    input wire logic output_gate_n,
    input wire logic write_pulse_n,
    input wire epc_pkg::epc_vpp_t vpp_sel
);
    // ************
    // helper logic
    // ************
    logic [11:0] low_cnt_q;
    // counts cycles of the current write pulse
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            low_cnt_q <= 12'h000;
        else if (write_pulse_n)
            low_cnt_q <= 12'h000;
        else
            low_cnt_q <= low_cnt_q + 12'h001;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ************
    // assertions
    // ************
    a_no_bus_fight: assert property (
        (!chip_select_n && !output_gate_n) |-> !data_lines_oe) else $error("data driven into read");
    a_pulse_width: assert property (
        $rose(write_pulse_n) |-> (low_cnt_q >= 12'h76c && low_cnt_q <= 12'h834))
        else $error("write pulse width out of range");
    a_pulse_max: assert property (
        low_cnt_q <= 12'h834) else $error("write pulse too long");
    a_pulse_selected: assert property (
        $fell(write_pulse_n) |-> !chip_select_n && output_gate_n
        && vpp_sel != epc_pkg::epc_vpp_normal) else $error("pulse outside program or erase");
    a_erase_setup: assert property (
        $fell(write_pulse_n) && vpp_sel == epc_pkg::epc_vpp_erase |-> id_erase_address_pin_hv
        && address_lines[8:0] == 9'h000 && address_lines[16:10] == 7'h00
        && data_lines_oe && data_lines_o == 8'hff) else $error("bad erase setup");
    a_prog_data: assert property (
        $fell(write_pulse_n) && vpp_sel == epc_pkg::epc_vpp_program |-> data_lines_oe)
        else $error("program pulse without data");
    a_pins_hold: assert property (
        !write_pulse_n |=> $stable(address_lines) && $stable(data_lines_o) && $stable(vpp_sel)
        && $stable(id_erase_address_pin_hv) && $stable(data_lines_oe))
        else $error("pins moved during pulse");
    a_verify_mode: assert property (
        $fell(output_gate_n) && vpp_sel != epc_pkg::epc_vpp_normal |-> write_pulse_n
        && !chip_select_n) else $error("bad verify setup");
    a_rsp_single: assert property (
        rsp_valid |=> !rsp_valid) else $error("response longer than one cycle");
    a_take_busy: assert property (
        cmd_valid && cmd_ready |=> !cmd_ready) else $error("ready after take");
    c_prog: cover property ($fell(write_pulse_n) && vpp_sel == epc_pkg::epc_vpp_program);
    c_erase: cover property ($fell(write_pulse_n) && vpp_sel == epc_pkg::epc_vpp_erase);
    c_id: cover property (!chip_select_n && !output_gate_n && id_erase_address_pin_hv);
endmodule

// ==== test/epc_mem_model.sv ====
// Purpose: behavioural model of the erasable parallel memory
// Assumes: pins driven by the controller, high voltages given by vpp_sel and hv flag
// Notes: released data lines show the inverse of the last output
`timescale 1ns/10ps
module epc_mem_model #(
    parameter logic [7:0] maker_code = 8'h3c, // arbitrary value
    parameter logic [7:0] part_code = 8'hc3 // arbitrary value
) (
    input wire logic [16:0] address_lines,
    input wire logic id_erase_address_pin_hv,
    input wire logic [7:0] data_lines,
    input wire logic chip_select_n,
    input wire logic output_gate_n,
    input wire logic write_pulse_n,
    input wire epc_pkg::epc_vpp_t vpp_sel,
    output logic [7:0] dout
);
    logic [7:0] mem [int]; // 17-bit address, absent entries read erased
    logic [7:0] rd_val;
    logic [7:0] last_q = 8'h00;
    logic drive;
    int wr_cnt = 0;
    function automatic logic [7:0] peek(input logic [16:0] a);
        return mem.exists(int'(a)) ? mem[int'(a)] : epc_pkg::epc_erased_byte;
    endfunction
    // pulses act only on a selected part with the gate high
    always @(negedge write_pulse_n)
    begin
        if (!chip_select_n && output_gate_n && vpp_sel == epc_pkg::epc_vpp_program)
            mem[int'(address_lines)] = peek(address_lines) & data_lines; // clears bits only
        else if (!chip_select_n && output_gate_n && vpp_sel == epc_pkg::epc_vpp_erase
            && id_erase_address_pin_hv && {address_lines[16:10], address_lines[8:0]} == 16'h0000
            && data_lines == 8'hff)
            mem.delete();
        wr_cnt = wr_cnt + 1;
    end
    assign drive = !chip_select_n && !output_gate_n;
    // wr_cnt in the list so a write refreshes the output
    always @(address_lines or id_erase_address_pin_hv or vpp_sel or wr_cnt)
    begin
        if (id_erase_address_pin_hv && vpp_sel == epc_pkg::epc_vpp_normal)
            rd_val = address_lines[0] ? part_code : maker_code;
        else
            rd_val = peek(address_lines); // margin reads look like plain reads
    end
    always @(drive or rd_val)
    begin
        if (drive)
            last_q = rd_val;
    end
    assign dout = drive ? rd_val : ~last_q; // released lines never hold the last byte
endmodule

// ==== test/tb_top.sv ====
// Purpose: self-checking bench for the memory programmer controller
// Assumes: 20 MHz ref_clk, shortened erase budget
// Notes: erase cannot finish verify in the short budget, so it must report failure
`timescale 1ns/10ps
module tb_top;
    localparam int unsigned budget = 20000;
    localparam logic [7:0] maker_c = 8'h3c; // arbitrary value
    localparam logic [7:0] part_c = 8'hc3; // arbitrary value
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    epc_pkg::epc_cmd_t cmd_op = epc_pkg::epc_cmd_read;
    logic [16:0] cmd_addr = 17'h00000;
    logic [7:0] cmd_wdata = 8'h00;
    logic cmd_ready, rsp_valid, rsp_error, hv, data_lines_oe, cs_n, og_n, wp_n;
    logic [7:0] rsp_rdata, data_lines_o, mem_dout, data_lines_i, rd;
    logic [16:0] address_lines;
    epc_pkg::epc_vpp_t vpp_sel;
    logic er;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    assign data_lines_i = data_lines_oe ? data_lines_o : mem_dout;
    epc_ctrl #(.erase_budget_cyc(budget)) epc_ctrl_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_error(rsp_error), .address_lines(address_lines), .id_erase_address_pin_hv(hv),
        .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe),
        .data_lines_i(data_lines_i), .chip_select_n(cs_n), .output_gate_n(og_n),
        .write_pulse_n(wp_n), .vpp_sel(vpp_sel));
    epc_mem_model #(.maker_code(maker_c), .part_code(part_c)) epc_mem_model_inst (
        .address_lines(address_lines), .id_erase_address_pin_hv(hv), .data_lines(data_lines_i),
        .chip_select_n(cs_n), .output_gate_n(og_n), .write_pulse_n(wp_n), .vpp_sel(vpp_sel),
        .dout(mem_dout));
    // clock and a hang guard well above the longest command
    initial
    begin
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 45000)
        begin
            n_fail++;
            stop_test();
        end
    end
    task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // one command: request held for the taking edge, answer sampled mid-cycle
    task automatic run(input epc_pkg::epc_cmd_t op, input logic [16:0] a, input logic [7:0] d);
        int n;
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_wdata <= d;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        for (n = 0; n < 30000 && rsp_valid !== 1'b1; n++)
            @(negedge ref_clk);
        check("rsp_valid", {16'h0000, rsp_valid}, 17'h00001);
        rd = rsp_rdata;
        er = rsp_error;
    endtask
    task automatic t_program();
        run(epc_pkg::epc_cmd_program, 17'h1abcd, 8'h5a);
        check("program error", {16'h0000, er}, 17'h00000);
        check("verify byte", {9'h000, rd}, {9'h000, 8'h5a});
        run(epc_pkg::epc_cmd_program, 17'h00000, 8'h00);
        check("program low error", {16'h0000, er}, 17'h00000);
        run(epc_pkg::epc_cmd_read, 17'h1abcd, 8'h00);
        check("read byte", {9'h000, rd}, {9'h000, 8'h5a});
        run(epc_pkg::epc_cmd_read, 17'h1ffff, 8'h00);
        check("read top", {9'h000, rd}, {9'h000, 8'hff});
        check("standby select", {16'h0000, cs_n}, 17'h00001);
        check("standby drive", {16'h0000, data_lines_oe}, 17'h00000);
    endtask
    task automatic t_id();
        run(epc_pkg::epc_cmd_id_maker, 17'h00000, 8'h00);
        check("maker id", {9'h000, rd}, {9'h000, maker_c});
        run(epc_pkg::epc_cmd_id_part, 17'h00000, 8'h00);
        check("part id", {9'h000, rd}, {9'h000, part_c});
    endtask
    task automatic t_erase();
        run(epc_pkg::epc_cmd_erase, 17'h00000, 8'h00);
        check("erase budget error", {16'h0000, er}, 17'h00001);
        run(epc_pkg::epc_cmd_read, 17'h1abcd, 8'h00);
        check("erased byte", {9'h000, rd}, {9'h000, 8'hff});
        run(epc_pkg::epc_cmd_read, 17'h00000, 8'h00);
        check("erased low", {9'h000, rd}, {9'h000, 8'hff});
    endtask
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_program();
        t_id();
        t_erase();
        stop_test();
    end
endmodule
bind epc_ctrl epc_ctrl_asserts #(.erase_budget_cyc(erase_budget_cyc)) epc_ctrl_asserts_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .address_lines(address_lines),
    .id_erase_address_pin_hv(id_erase_address_pin_hv), .data_lines_o(data_lines_o),
    .data_lines_oe(data_lines_oe), .chip_select_n(chip_select_n),
    .output_gate_n(output_gate_n), .write_pulse_n(write_pulse_n), .vpp_sel(vpp_sel));
